/* File: src/bfsup_top.sv */
`timescale 1ns/100ps
`include "bfsup_params.svh"
// Breaker failure supervisor with APB register access.
module bfsup_top
	import bfsup_pkg::*;
(
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        reset,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Trip commands assigned to the breaker.
	input  wire logic        trip_external,
	input  wire logic        trip_current,
	input  wire logic        trip_other,
	input  wire logic [2:0]  extra_trigger_in,
	// Breaker measurement and position.
	input  wire logic [15:0] phase_current,
	input  wire logic        breaker_open,
	// Operator acknowledge.
	input  wire logic        operator_panel_ack,
	// Outputs.
	output logic             backup_trip,
	output logic             failure_lock,
	output logic             close_block,
	output logic             irq
);
	bfsup_state_e  state_reg;
	bfsup_state_e  state_next;
	logic [3:0]    ctrl_reg;
	logic [31:0]   time_reg;
	logic [15:0]   thresh_reg;
	logic [31:0]   elapsed_reg;
	logic          lock_reg;
	logic          trip_reg;
	logic [2:0]    irq_stat_reg;
	logic [2:0]    irq_mask_reg;
	logic [31:0]   prdata_reg;
	logic          tick;

	bfsup_tick u_tick
	(
		.clock (clock),
		.reset (reset),
		.tick  (tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Bus decode.
	////////////////////////////////////////////////////////////////////////////

	// Address decode and strobes; the slave answers in the first access cycle.
	wire         wr_en     = psel && penable && pwrite;
	wire         rd_en     = psel && penable && !pwrite;
	wire         hit_ctrl  = (paddr == `BFSUP_CTRL_OFF);
	wire         hit_time  = (paddr == `BFSUP_TIME_OFF);
	wire         hit_thr   = (paddr == `BFSUP_THRESH_OFF);
	wire         hit_stat  = (paddr == `BFSUP_STATUS_OFF);
	wire         hit_istat = (paddr == `BFSUP_IRQ_STAT_OFF);
	wire         hit_imask = (paddr == `BFSUP_IRQ_MASK_OFF);
	wire         hit_ack   = (paddr == `BFSUP_ACK_OFF);
	wire         mapped    = hit_ctrl | hit_time | hit_thr | hit_stat | hit_istat | hit_imask | hit_ack;
	wire         sw_ack    = wr_en && hit_ack && pwdata[0];
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	////////////////////////////////////////////////////////////////////////////
	// Trigger and opening detection.
	////////////////////////////////////////////////////////////////////////////

	wire bfsup_scheme_e scheme   = bfsup_scheme_e'(ctrl_reg[`BFSUP_SCHEME_LSB +: 2]);
	wire bfsup_trig_e   trigmode = bfsup_trig_e'(ctrl_reg[`BFSUP_TRIGMODE_LSB +: 2]);

	// Assigned trip commands picked by the trigger mode.
	wire cmd_all   = (trigmode == all_commands_mode) && (trip_external | trip_current | trip_other);
	wire cmd_ext   = (trigmode == external_commands_mode) && trip_external;
	wire cmd_cur   = (trigmode == current_commands_mode) && trip_current;
	// No commands mode selects none of them, leaving the extra inputs.
	wire cmd_sel   = cmd_all | cmd_ext | cmd_cur;
	wire trigger   = cmd_sel | (|extra_trigger_in);

	// Current still flowing and position evidence.
	wire cur_high  = (phase_current >= thresh_reg);
	wire pos_shut  = !breaker_open;
	// Failure condition per scheme; opening is its negation.
	wire fail_cond = (scheme == current_only_scheme) ? cur_high :
		(scheme == position_only_scheme) ? pos_shut :
		(cur_high && pos_shut);
	wire opened    = !fail_cond;
	wire expired   = tick && (elapsed_reg + 32'h0000_0001 >= time_reg);

	////////////////////////////////////////////////////////////////////////////
	// State machine.
	////////////////////////////////////////////////////////////////////////////

	// Next state selection.
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			st_standby:
			begin
				if (trigger)
					state_next = st_running;
			end
			st_running:
			begin
				if (opened)
					state_next = trigger ? st_rejected : st_standby;
				else if (expired)
					state_next = st_tripped;
			end
			st_rejected:
			begin
				if (!trigger)
					state_next = st_standby;
			end
			st_tripped:
			begin
				if (opened && !trigger)
					state_next = st_standby;
			end
		endcase
	end

	// State, timer, trip and lock registers.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			state_reg   <= st_standby;
			elapsed_reg <= 32'h0000_0000;
			trip_reg    <= 1'b0;
			lock_reg    <= 1'b0;
		end
		else
		begin
			state_reg   <= state_next;
			// Timer keeps counting regardless of trigger once running.
			if (state_reg != st_running)
				elapsed_reg <= 32'h0000_0000;
			else if (tick)
				elapsed_reg <= elapsed_reg + 32'h0000_0001;
			trip_reg    <= (state_next == st_tripped);
			// Set wins over the acknowledge.
			if (state_next == st_tripped)
				lock_reg <= 1'b1;
			else if (operator_panel_ack || sw_ack)
				lock_reg <= 1'b0;
		end
	end

	assign backup_trip  = trip_reg;
	assign failure_lock = lock_reg;
	assign close_block  = lock_reg;

	////////////////////////////////////////////////////////////////////////////
	// Registers and interrupts.
	////////////////////////////////////////////////////////////////////////////

	// Events: trip onset, rejection, lock release.
	wire [2:0] events = {(lock_reg && !(state_next == st_tripped) && (operator_panel_ack || sw_ack)),
		(state_reg == st_running && state_next == st_rejected),
		(state_reg != st_tripped && state_next == st_tripped)};
	wire [2:0] w1c    = (wr_en && hit_istat) ? pwdata[2:0] : 3'h0;
	assign irq = |(irq_stat_reg & irq_mask_reg);

	// Software registers.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			ctrl_reg     <= `BFSUP_CTRL_RST;
			time_reg     <= `BFSUP_TIME_RST;
			thresh_reg   <= `BFSUP_THRESH_RST;
			irq_stat_reg <= 3'h0;
			irq_mask_reg <= 3'h0;
		end
		else
		begin
			if (wr_en && hit_ctrl)
				ctrl_reg <= pwdata[3:0];
			if (wr_en && hit_time)
				time_reg <= pwdata;
			if (wr_en && hit_thr)
				thresh_reg <= pwdata[15:0];
			if (wr_en && hit_imask)
				irq_mask_reg <= pwdata[2:0];
			irq_stat_reg <= (irq_stat_reg & ~w1c) | events;
		end
	end

	// Read mux.
	wire [31:0] rd_mux = hit_ctrl  ? {28'h0, ctrl_reg} :
		hit_time  ? time_reg :
		hit_thr   ? {16'h0, thresh_reg} :
		hit_stat  ? {27'h0, trigger, lock_reg, trip_reg, state_reg} :
		hit_istat ? {29'h0, irq_stat_reg} :
		hit_imask ? {29'h0, irq_mask_reg} : 32'h0000_0000;

	// Read data register, loaded during setup.
	always_ff @(posedge clock)
	begin
		if (reset)
			prdata_reg <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata_reg <= rd_mux;
	end
	assign prdata = prdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// Assertions.
	////////////////////////////////////////////////////////////////////////////

	sequence s_trip_now;
		state_reg == st_tripped;
	endsequence

	a_lock_with_trip: assert property (@(posedge clock) disable iff (reset)
		backup_trip |-> failure_lock)
		else $error("lock not asserted with trip");
	a_lock_holds: assert property (@(posedge clock) disable iff (reset)
		failure_lock && !operator_panel_ack && !sw_ack |=> failure_lock)
		else $error("lock dropped without acknowledge");
	a_close_blocked: assert property (@(posedge clock) disable iff (reset)
		close_block == failure_lock)
		else $error("close block differs from lock");
	a_trip_cause: assert property (@(posedge clock) disable iff (reset)
		$rose(backup_trip) |-> $past(state_reg) == st_running && $past(expired))
		else $error("trip without expiry");
	a_trip_state: assert property (@(posedge clock) disable iff (reset)
		s_trip_now |-> backup_trip)
		else $error("tripped state without trip");
	a_reject_hold: assert property (@(posedge clock) disable iff (reset)
		state_reg == st_rejected && trigger |=> state_reg == st_rejected)
		else $error("left rejected while triggered");
	a_reject_exit: assert property (@(posedge clock) disable iff (reset)
		state_reg == st_rejected && !trigger |=> state_reg == st_standby)
		else $error("rejected did not return to stand-by");
	a_start_timer: assert property (@(posedge clock) disable iff (reset)
		state_reg == st_standby && trigger |=> state_reg == st_running)
		else $error("trigger did not start timer");
	a_extra_trig: assert property (@(posedge clock) disable iff (reset)
		|extra_trigger_in |-> trigger)
		else $error("extra input ignored");
	a_none_mode: assert property (@(posedge clock) disable iff (reset)
		trigmode == no_commands_mode && extra_trigger_in == 3'h0 |-> !trigger)
		else $error("command started unit in none mode");
	a_stop_open: assert property (@(posedge clock) disable iff (reset)
		state_reg == st_running && opened |=> state_reg != st_tripped)
		else $error("tripped after opening");
endmodule : bfsup_top

/* File: src/bfsup_params.svh */
`ifndef BFSUP_PARAMS_SVH
`define BFSUP_PARAMS_SVH

// Register byte offsets.
`define BFSUP_CTRL_OFF      12'h000
`define BFSUP_TIME_OFF      12'h004
`define BFSUP_THRESH_OFF    12'h008
`define BFSUP_STATUS_OFF    12'h00C
`define BFSUP_IRQ_STAT_OFF  12'h010
`define BFSUP_IRQ_MASK_OFF  12'h014
`define BFSUP_ACK_OFF       12'h018
// Control field positions.
`define BFSUP_SCHEME_LSB    0
`define BFSUP_TRIGMODE_LSB  2
// Reset values.
`define BFSUP_CTRL_RST      4'h0
`define BFSUP_TIME_RST      32'h0000_03E8
`define BFSUP_THRESH_RST    16'h0100
// Timer tick: one microsecond at 100 MHz, so a full run stays short.
`define BFSUP_CLOCK_HZ      100000000
`define BFSUP_TICK_US       1
`define BFSUP_TICK_CYCLES   ((`BFSUP_CLOCK_HZ / 1000000) * `BFSUP_TICK_US)
`endif

/* File: src/bfsup_pkg.sv */
package bfsup_pkg;
	// Supervision schemes.
	typedef enum logic [1:0] {current_only_scheme, position_only_scheme, current_and_position_scheme,
		scheme_spare} bfsup_scheme_e;
	// Trigger modes.
	typedef enum logic [1:0] {all_commands_mode, external_commands_mode, current_commands_mode,
		no_commands_mode} bfsup_trig_e;
	// Unit states.
	typedef enum logic [1:0] {st_standby, st_running, st_rejected, st_tripped} bfsup_state_e;
endpackage : bfsup_pkg

/* File: src/bfsup_tick.sv */
`timescale 1ns/100ps
`include "bfsup_params.svh"
// Divider producing one-cycle timer enable pulses.
module bfsup_tick
	import bfsup_pkg::*;
(
	// Clock and reset.
	input  wire logic clock,
	input  wire logic reset,
	// Tick output.
	output logic      tick
);
	localparam logic [31:0] LAST = 32'(`BFSUP_TICK_CYCLES - 1);
	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic        wrap;

	// Wrap detection and next count.
	assign wrap       = (count_reg == LAST);
	assign count_next = wrap ? 32'h0000_0000 : count_reg + 32'h0000_0001;
	assign tick       = wrap;

	// Counter register.
	always_ff @(posedge clock)
	begin
		if (reset)
			count_reg <= 32'h0000_0000;
		else
			count_reg <= count_next;
	end
endmodule : bfsup_tick

/* File: verification/bfsup_breaker_model.sv */
`timescale 1ns/100ps
// Behavioural breaker: position contact and phase current seen by the supervisor.
module bfsup_breaker_model
#(
	parameter logic [15:0] LOAD = 16'h0100
)
(
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        reset,
	// Commands from the bench.
	input  wire logic        open_cmd,
	input  wire logic [1:0]  fault_mode,
	input  wire logic [7:0]  open_delay,
	// Breaker outputs.
	output logic      [15:0] phase_current,
	output logic             breaker_open
);
	logic [7:0] wait_reg;
	logic       moved_reg;
	////////////////////////////////
	// Contacts part open_delay+1 cycles after the command, well inside the reset supervision time.
	always_ff @(posedge clock)
	begin
		if (reset || !open_cmd)
		begin
			wait_reg  <= 8'h00;
			moved_reg <= 1'b0;
		end
		else if (wait_reg == open_delay)
			moved_reg <= 1'b1;
		else
			wait_reg <= wait_reg + 8'h01;
	end
	// Fault 1 sticks shut, 2 shows open while current flows, 3 leaves current one step under load.
	assign breaker_open  = moved_reg && (fault_mode == 2'h0 || fault_mode == 2'h2);
	assign phase_current = (!moved_reg || fault_mode == 2'h1 || fault_mode == 2'h2) ? LOAD :
		(fault_mode == 2'h3 ? LOAD - 16'h0001 : 16'h0000);
endmodule : bfsup_breaker_model

/* File: verification/tb_bfsup_top.sv */
`timescale 1ns/100ps
`include "bfsup_params.svh"
// Self-checking bench for the breaker failure supervisor.
module tb_bfsup_top import bfsup_pkg::*;;
	logic        clock, reset, psel, penable, pwrite, pready, pslverr, err;
	logic        trip_external, trip_current, trip_other, breaker_open, operator_panel_ack;
	logic        backup_trip, failure_lock, close_block, irq, open_cmd;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] phase_current;
	logic [2:0]  extra_trigger_in;
	logic [1:0]  fault_mode;
	logic [7:0]  open_delay;
	logic [8:0]  trig_rows [13];
	logic [4:0]  scheme_rows [8];
	int          error_cnt = 0;
	int          checked = 0;
	int          cyc = 0;
	bfsup_top dut_u (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.trip_external(trip_external), .trip_current(trip_current), .trip_other(trip_other),
		.extra_trigger_in(extra_trigger_in), .phase_current(phase_current), .breaker_open(breaker_open),
		.operator_panel_ack(operator_panel_ack), .backup_trip(backup_trip), .failure_lock(failure_lock),
		.close_block(close_block), .irq(irq));
	bfsup_breaker_model brk_u (.clock(clock), .reset(reset), .open_cmd(open_cmd), .fault_mode(fault_mode),
		.open_delay(open_delay), .phase_current(phase_current), .breaker_open(breaker_open));
	////////////////////////////////
	// One APB transfer; the request stands until pready is seen high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic state_is(input bfsup_state_e s);
		apb(1'b0, `BFSUP_STATUS_OFF, 32'h0);
		check({30'h0, rd[1:0]}, {30'h0, s});
	endtask : state_is
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	// Clock and hang guard.
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			end_of_test();
		end
	end
	// Main sequence: reset, two row tables, then interrupt and trip by hand.
	initial
	begin
		{reset, psel, penable, pwrite, paddr, pwdata} = {3'h4, 45'h0};
		{trip_external, trip_current, trip_other, extra_trigger_in, operator_panel_ack} = 7'h00;
		{open_cmd, fault_mode, open_delay} = {3'h0, 8'h30};
		trig_rows = '{9'h041, 9'h021, 9'h011, 9'h0C1, 9'h0A0, 9'h090, 9'h121, 9'h140, 9'h110,
			9'h1F0, 9'h183, 9'h185, 9'h189};
		scheme_rows = '{5'h07, 5'h04, 5'h0D, 5'h0E, 5'h15, 5'h17, 5'h12, 5'h1D};
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		check({28'h0, backup_trip, failure_lock, close_block, irq}, 32'h0);
		apb(1'b0, `BFSUP_TIME_OFF, 32'h0);
		check(rd, `BFSUP_TIME_RST);
		apb(1'b0, `BFSUP_THRESH_OFF, 32'h0);
		check(rd, {16'h0, `BFSUP_THRESH_RST});
		apb(1'b0, 12'h01C, 32'h0);
		check({rd[30:0], err}, 32'h1);
		$display("test reset done");
		foreach (trig_rows[i])
		begin
			apb(1'b1, `BFSUP_CTRL_OFF, {28'h0, trig_rows[i][8:7], 2'h0});
			{trip_external, trip_current, trip_other} <= trig_rows[i][6:4];
			extra_trigger_in <= trig_rows[i][3:1];
			repeat (3) @(posedge clock);
			state_is(trig_rows[i][0] ? st_running : st_standby);
			{trip_external, trip_current, trip_other, extra_trigger_in} <= 6'h00;
			open_cmd <= 1'b1;
			repeat (60) @(posedge clock);
			state_is(st_standby);
			open_cmd <= 1'b0;
		end
		$display("test trigger modes done");
		open_delay <= 8'h04;
		foreach (scheme_rows[i])
		begin
			apb(1'b1, `BFSUP_CTRL_OFF, {30'h0, scheme_rows[i][4:3]});
			fault_mode <= scheme_rows[i][2:1];
			trip_external <= 1'b1;
			repeat (3) @(posedge clock);
			open_cmd <= 1'b1;
			repeat (12) @(posedge clock);
			state_is(scheme_rows[i][0] ? st_rejected : st_running);
			{trip_external, fault_mode} <= 3'h0;
			repeat (8) @(posedge clock);
			state_is(st_standby);
			open_cmd <= 1'b0;
		end
		$display("test schemes done");
		check({31'h0, irq}, 32'h0);
		apb(1'b1, `BFSUP_IRQ_MASK_OFF, 32'h2);
		@(posedge clock);
		check({31'h0, irq}, 32'h1);
		apb(1'b1, `BFSUP_IRQ_STAT_OFF, 32'h2);
		@(posedge clock);
		check({31'h0, irq}, 32'h0);
		$display("test interrupt done");
		apb(1'b1, `BFSUP_TIME_OFF, 32'h2);
		apb(1'b1, `BFSUP_IRQ_MASK_OFF, 32'h1);
		{fault_mode, open_cmd, trip_current} <= 4'h7;
		repeat (2) @(posedge clock);
		trip_current <= 1'b0;
		repeat (3) @(posedge clock);
		state_is(st_running);
		for (int n = 0; n < 2000 && backup_trip !== 1'b1; n++) @(posedge clock);
		check({29'h0, backup_trip, failure_lock, close_block}, 32'h7);
		check({31'h0, irq}, 32'h1);
		apb(1'b0, `BFSUP_STATUS_OFF, 32'h0);
		check({27'h0, rd[4:0]}, 32'hF);
		fault_mode <= 2'h0;
		repeat (12) @(posedge clock);
		check({29'h0, backup_trip, failure_lock, close_block}, 32'h3);
		operator_panel_ack <= 1'b1;
		@(posedge clock);
		operator_panel_ack <= 1'b0;
		repeat (3) @(posedge clock);
		check({30'h0, failure_lock, close_block}, 32'h0);
		apb(1'b0, `BFSUP_IRQ_STAT_OFF, 32'h0);
		check(rd, 32'h5);
		$display("test trip and lock done");
		end_of_test();
	end
endmodule : tb_bfsup_top
